// File: logic/uhps_pkg.sv
// Purpose: shared constants and types of the host pipe status and interrupt block
// Assumes: 8-bit register port, four pipes, one system clock
// Notes:   register offsets are byte addresses on the plain register port
package uhps_pkg;

    // =====================================================================
    // sizes
    localparam int unsigned NUM_PIPES = 4;
    localparam int unsigned PIPE_W    = 2;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 8;

    // =====================================================================
    // register offsets
    localparam logic [7:0] OFS_INT_SUMMARY = 8'h9a;
    localparam logic [7:0] OFS_ERROR_STAT  = 8'h9d;
    localparam logic [7:0] OFS_IN_REQ_CNT  = 8'ha5;
    localparam logic [7:0] OFS_INT_FLAGS   = 8'ha6;
    localparam logic [7:0] OFS_PIPE_SELECT = 8'ha7;
    localparam logic [7:0] OFS_PIPE_CTRL   = 8'ha9;
    localparam logic [7:0] OFS_PIPE_CFG    = 8'haa;
    localparam logic [7:0] OFS_PIPE_STAT   = 8'hac;
    localparam logic [7:0] OFS_INT_ENABLE  = 8'hae;

    // =====================================================================
    // reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [1:0] RST_PAIR  = 2'h0;
    localparam logic [4:0] RST_ERRS  = 5'h00;
    localparam logic [3:0] RST_PIPES = 4'h0;

    // =====================================================================
    // error status fields
    localparam int unsigned ERR_TALLY_LSB = 5;
    localparam int unsigned ERR_TALLY_MSB = 6;
    localparam int unsigned ERR_SRC_MSB   = 4;
    localparam logic [1:0]  TALLY_FREEZE  = 2'h3;

    // =====================================================================
    // interrupt flag / enable bit positions
    localparam int unsigned BIT_HANDOVER = 7;
    localparam int unsigned BIT_NAK      = 6;
    localparam int unsigned BIT_RW_ALLOW = 5;
    localparam int unsigned BIT_FLOW_IE  = 7;
    localparam int unsigned BIT_PERR     = 4;
    localparam int unsigned BIT_SETUP    = 3;
    localparam int unsigned BIT_OUT      = 2;
    localparam int unsigned BIT_STALL    = 1;
    localparam int unsigned BIT_IN_RCV   = 0;

    // =====================================================================
    // control, configuration and status fields
    localparam int unsigned CTRL_FREEZE = 6;
    localparam int unsigned CTRL_INMODE = 5;
    localparam int unsigned STAT_OVF    = 6;
    localparam int unsigned STAT_UNF    = 5;
    localparam int unsigned CFG_TYPE_LSB  = 6;
    localparam int unsigned CFG_TOKEN_LSB = 4;

    // busy bank encoding
    localparam logic [1:0] BANKS_FREE = 2'h0;
    localparam logic [1:0] BANKS_MAX  = 2'h2;

    // pipe type and token encodings
    localparam logic [1:0] TYPE_ISO    = 2'h1;
    localparam logic [1:0] TOKEN_SETUP = 2'h0;
    localparam logic [1:0] TOKEN_IN    = 2'h1;
    localparam logic [1:0] TOKEN_OUT   = 2'h2;

    // one event from the serial engine, tagged with the pipe it concerns
    typedef struct packed {
        logic              valid;
        logic [PIPE_W-1:0] pipe;
        logic              in_stored;
        logic              bank_freed;
        logic              nak;
        logic              stall;
        logic              iso_crc;
        logic              data_crc_error;
        logic              time_out;
        logic              pid_err;
        logic              data_pid;
        logic              toggle;
        logic              overflow;
        logic              underflow;
        logic              in_req_done;
        logic              rw_set;
        logic              rw_clear;
    } uhps_evt_t;

endpackage : uhps_pkg

// File: logic/uhps_pipe_status.sv
// Purpose: per-pipe status, error, IN request and interrupt logic of a USB host
// Assumes: events arrive one per cycle from the serial engine, synchronous to ref_clk
// Notes:   all per-pipe registers are banked and reached through pipe_select
//
// Summary of operation
// - firmware loads pipe_select first; banked registers then map onto that pipe.
// - busy_bank_count is two bits: 00 free, 01 one busy, 10 two busy.
// - OUT pipes count firmware-filled banks; IN pipes count banks filled from device.
// - issue in_request_count plus one IN requests, then freeze the pipe.
// - each successful IN request decrements in_request_count by one.
// - two-bit error tally counts errors, freezes at three, software writes load it from bits 6:5.
// - separate sticky flags for CRC, time-out, PID, data PID and toggle errors.
// - software may only clear hardware flags; writing one leaves them unchanged.
// - OUT/SETUP: bank_handover set with bank-ready; software clear sends the bank.
// - IN: bank_handover set on stored message; software clear frees, switches bank.
// - nak_received_flag set on NAK, interrupts when enabled, software clears.
// - OUT pipe: rw_allowed high while a byte may be written, low when full.
// - IN pipe: rw_allowed high while a byte may be read, low when empty.
// - rw_allowed forced low when stall or pipe error flag becomes set.
// - pipe_error_flag follows the error sources and clears once they are cleared.
// - setup_bank_ready set when SETUP bank free; interrupts when enabled.
// - out_bank_ready set when OUT bank free; interrupts when enabled.
// - STALL sets stall_received_flag and freezes the pipe; interrupts when enabled.
// - isochronous pipes use that bit for CRC errors, enabled by setup_ready_ie.
// - in_data_received set when a message is stored; interrupts when enabled.
// - flow_error_ie bit 7 gates both overflow and underflow interrupts.
// - each other enable gates its own flag; enable bit 5 reads zero.
// - hardware sets pipe_freeze after IN requests, on STALL or on pipe error.
// - summary bit per pipe shows an enabled pending interrupt, clears when served.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns

module uhps_pipe_status (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        reset,
    // register port
    input  wire logic [uhps_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [uhps_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [uhps_pkg::DATA_W-1:0] reg_rdata,
    // serial engine events
    input  wire uhps_pkg::uhps_evt_t         evt,
    // serial engine controls
    output logic      [uhps_pkg::NUM_PIPES-1:0] pipe_freeze,
    output logic      [uhps_pkg::NUM_PIPES-1:0] handover_release,
    output logic      [uhps_pkg::NUM_PIPES-1:0] pipe_irq
);

    localparam int unsigned NP = uhps_pkg::NUM_PIPES;

    // =====================================================================
    // pipe select
    logic [uhps_pkg::PIPE_W-1:0] pipe_select_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pipe_select_ff <= uhps_pkg::RST_PAIR;
        end else if (reg_wr && reg_addr == uhps_pkg::OFS_PIPE_SELECT) begin
            pipe_select_ff <= reg_wdata[uhps_pkg::PIPE_W-1:0];
        end
    end

    // =====================================================================
    // banked per-pipe state
    logic [4:0] err_src_ff   [NP];
    logic [1:0] err_tally_ff [NP];
    logic [7:0] in_req_ff    [NP];
    logic [7:0] ie_ff        [NP];
    logic [7:0] cfg_ff       [NP];
    logic [1:0] busy_ff      [NP];
    logic       handover_ff  [NP];
    logic       nak_ff       [NP];
    logic       rw_allow_ff  [NP];
    logic       setup_rdy_ff [NP];
    logic       out_rdy_ff   [NP];
    logic       stall_ff     [NP];
    logic       in_rcv_ff    [NP];
    logic       ovf_ff       [NP];
    logic       unf_ff       [NP];
    logic       inmode_ff    [NP];
    logic [NP-1:0] freeze_ff;
    logic [NP-1:0] release_ff;
    logic [NP-1:0] summary_ff;
    logic [NP-1:0] irq_now;
    logic [7:0]    flags_rd [NP];

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_pipe
            logic       sel;
            logic       ev;
            logic       wr_err;
            logic       wr_flags;
            logic       wr_stat;
            logic       wr_ctrl;
            logic       is_in;
            logic       is_iso;
            logic       is_setup;
            logic [4:0] err_set;
            logic       any_err;
            logic       perr;
            logic       stall_set;
            logic       sw_release;
            logic [1:0] tally_base;
            logic [1:0] tally_nxt;
            logic [7:0] req_base;
            logic       req_done;
            logic       req_exhaust;
            logic       bank_up;
            logic       bank_dn;

            assign sel      = (pipe_select_ff == uhps_pkg::PIPE_W'(gi));
            assign ev       = evt.valid && (evt.pipe == uhps_pkg::PIPE_W'(gi));
            assign wr_err   = reg_wr && sel && reg_addr == uhps_pkg::OFS_ERROR_STAT;
            assign wr_flags = reg_wr && sel && reg_addr == uhps_pkg::OFS_INT_FLAGS;
            assign wr_stat  = reg_wr && sel && reg_addr == uhps_pkg::OFS_PIPE_STAT;
            assign wr_ctrl  = reg_wr && sel && reg_addr == uhps_pkg::OFS_PIPE_CTRL;
            assign is_in    = cfg_ff[gi][uhps_pkg::CFG_TOKEN_LSB+:2] == uhps_pkg::TOKEN_IN;
            assign is_setup = cfg_ff[gi][uhps_pkg::CFG_TOKEN_LSB+:2] == uhps_pkg::TOKEN_SETUP;
            assign is_iso   = cfg_ff[gi][uhps_pkg::CFG_TYPE_LSB+:2] == uhps_pkg::TYPE_ISO;

            assign err_set  = ev ? {evt.data_crc_error, evt.time_out, evt.pid_err,
                                    evt.data_pid, evt.toggle} : uhps_pkg::RST_ERRS;
            assign any_err  = |err_set;
            assign perr     = |err_src_ff[gi];
            assign stall_set = ev && evt.stall && !is_iso;

            // firmware writing zero over a set handover bit hands the bank back
            assign sw_release = wr_flags && handover_ff[gi] && !reg_wdata[uhps_pkg::BIT_HANDOVER];

            // ----- error sources and tally
            assign tally_base = wr_err ? reg_wdata[uhps_pkg::ERR_TALLY_MSB:uhps_pkg::ERR_TALLY_LSB]
                                       : err_tally_ff[gi];
            assign tally_nxt  = (any_err && tally_base != uhps_pkg::TALLY_FREEZE)
                                ? tally_base + 2'h1 : tally_base;

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    err_src_ff[gi]   <= uhps_pkg::RST_ERRS;
                    err_tally_ff[gi] <= uhps_pkg::RST_PAIR;
                end else begin
                    // an error in the clearing cycle still lands
                    err_src_ff[gi]   <= (wr_err ? err_src_ff[gi] & reg_wdata[4:0]
                                                : err_src_ff[gi]) | err_set;
                    err_tally_ff[gi] <= tally_nxt;
                end
            end

            // ----- IN request counter
            assign req_base    = (reg_wr && sel && reg_addr == uhps_pkg::OFS_IN_REQ_CNT)
                                 ? reg_wdata : in_req_ff[gi];
            assign req_done    = ev && evt.in_req_done;
            assign req_exhaust = req_done && req_base == uhps_pkg::RST_BYTE && !inmode_ff[gi];

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    in_req_ff[gi] <= uhps_pkg::RST_BYTE;
                end else if (req_done && req_base != uhps_pkg::RST_BYTE) begin
                    in_req_ff[gi] <= req_base - 8'h01;
                end else begin
                    in_req_ff[gi] <= req_base;
                end
            end

            // ----- enables and configuration
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    ie_ff[gi]  <= uhps_pkg::RST_BYTE;
                    cfg_ff[gi] <= uhps_pkg::RST_BYTE;
                end else begin
                    if (reg_wr && sel && reg_addr == uhps_pkg::OFS_INT_ENABLE) begin
                        ie_ff[gi] <= reg_wdata & 8'hdf;
                    end
                    if (reg_wr && sel && reg_addr == uhps_pkg::OFS_PIPE_CFG) begin
                        cfg_ff[gi] <= reg_wdata;
                    end
                end
            end

            // ----- freeze and request mode
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    freeze_ff[gi] <= 1'b0;
                    inmode_ff[gi] <= 1'b0;
                end else begin
                    if (wr_ctrl) begin
                        inmode_ff[gi] <= reg_wdata[uhps_pkg::CTRL_INMODE];
                    end
                    // hardware freeze causes win over a software unfreeze
                    if (req_exhaust) begin
                        freeze_ff[gi] <= 1'b1;
                    end else if (stall_set) begin
                        freeze_ff[gi] <= 1'b1;
                    end else if (any_err || tally_nxt == uhps_pkg::TALLY_FREEZE) begin
                        freeze_ff[gi] <= 1'b1;
                    end else if (wr_ctrl) begin
                        freeze_ff[gi] <= reg_wdata[uhps_pkg::CTRL_FREEZE];
                    end
                end
            end

            // ----- busy banks, saturated at two
            assign bank_up = is_in ? (ev && evt.in_stored) : sw_release;
            assign bank_dn = is_in ? sw_release : (ev && evt.bank_freed);

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    busy_ff[gi] <= uhps_pkg::BANKS_FREE;
                end else if (bank_up && !bank_dn && busy_ff[gi] != uhps_pkg::BANKS_MAX) begin
                    busy_ff[gi] <= busy_ff[gi] + 2'h1;
                end else if (bank_dn && !bank_up && busy_ff[gi] != uhps_pkg::BANKS_FREE) begin
                    busy_ff[gi] <= busy_ff[gi] - 2'h1;
                end
            end

            // ----- interrupt flags: set beats a same-cycle software clear
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    handover_ff[gi]  <= 1'b0;
                    nak_ff[gi]       <= 1'b0;
                    setup_rdy_ff[gi] <= 1'b0;
                    out_rdy_ff[gi]   <= 1'b0;
                    stall_ff[gi]     <= 1'b0;
                    in_rcv_ff[gi]    <= 1'b0;
                end else begin
                    handover_ff[gi]  <= (wr_flags ? handover_ff[gi] &
                                         reg_wdata[uhps_pkg::BIT_HANDOVER] : handover_ff[gi])
                                        | (ev && (is_in ? evt.in_stored
                                                        : evt.bank_freed));
                    nak_ff[gi]       <= (wr_flags ? nak_ff[gi] & reg_wdata[uhps_pkg::BIT_NAK]
                                                  : nak_ff[gi]) | (ev && evt.nak);
                    setup_rdy_ff[gi] <= (wr_flags ? setup_rdy_ff[gi] &
                                         reg_wdata[uhps_pkg::BIT_SETUP] : setup_rdy_ff[gi])
                                        | (ev && evt.bank_freed && is_setup);
                    out_rdy_ff[gi]   <= (wr_flags ? out_rdy_ff[gi] &
                                         reg_wdata[uhps_pkg::BIT_OUT] : out_rdy_ff[gi])
                                        | (ev && evt.bank_freed && !is_setup
                                           && !is_in);
                    stall_ff[gi]     <= (wr_flags ? stall_ff[gi] &
                                         reg_wdata[uhps_pkg::BIT_STALL] : stall_ff[gi])
                                        | stall_set
                                        | (ev && evt.iso_crc && is_iso);
                    in_rcv_ff[gi]    <= (wr_flags ? in_rcv_ff[gi] &
                                         reg_wdata[uhps_pkg::BIT_IN_RCV] : in_rcv_ff[gi])
                                        | (ev && evt.in_stored);
                end
            end

            // ----- flow errors
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    ovf_ff[gi] <= 1'b0;
                    unf_ff[gi] <= 1'b0;
                end else begin
                    ovf_ff[gi] <= (wr_stat ? ovf_ff[gi] & reg_wdata[uhps_pkg::STAT_OVF]
                                           : ovf_ff[gi]) | (ev && evt.overflow);
                    unf_ff[gi] <= (wr_stat ? unf_ff[gi] & reg_wdata[uhps_pkg::STAT_UNF]
                                           : unf_ff[gi]) | (ev && evt.underflow);
                end
            end

            // ----- read/write allowed; a stall or error blocks FIFO access at once
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    rw_allow_ff[gi] <= 1'b0;
                end else if (stall_set || any_err) begin
                    rw_allow_ff[gi] <= 1'b0;
                end else if (ev && evt.rw_clear) begin
                    rw_allow_ff[gi] <= 1'b0;
                end else if (ev && evt.rw_set) begin
                    rw_allow_ff[gi] <= 1'b1;
                end
            end

            // ----- release pulse and interrupt
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    release_ff[gi] <= 1'b0;
                    summary_ff[gi] <= 1'b0;
                end else begin
                    release_ff[gi] <= sw_release;
                    summary_ff[gi] <= irq_now[gi];
                end
            end

            assign irq_now[gi] =
                  (nak_ff[gi]       & ie_ff[gi][uhps_pkg::BIT_NAK])
                | (perr             & ie_ff[gi][uhps_pkg::BIT_PERR])
                | (setup_rdy_ff[gi] & ie_ff[gi][uhps_pkg::BIT_SETUP])
                | (out_rdy_ff[gi]   & ie_ff[gi][uhps_pkg::BIT_OUT])
                | (stall_ff[gi]     & ie_ff[gi][is_iso ? uhps_pkg::BIT_SETUP
                                                       : uhps_pkg::BIT_STALL])
                | (in_rcv_ff[gi]    & ie_ff[gi][uhps_pkg::BIT_IN_RCV])
                | ((ovf_ff[gi] | unf_ff[gi]) & ie_ff[gi][uhps_pkg::BIT_FLOW_IE]);

            assign flags_rd[gi] = {handover_ff[gi], nak_ff[gi], rw_allow_ff[gi], perr,
                                   setup_rdy_ff[gi], out_rdy_ff[gi], stall_ff[gi], in_rcv_ff[gi]};
        end
    endgenerate

    // =====================================================================
    // read port: data stand in the cycle after the strobe
    logic [7:0] rdata_ff;
    logic [7:0] rd_mux;
    logic [uhps_pkg::PIPE_W-1:0] s;

    always_comb begin
        s = pipe_select_ff;
        case (reg_addr)
            uhps_pkg::OFS_INT_SUMMARY: rd_mux = {4'h0, summary_ff};
            uhps_pkg::OFS_ERROR_STAT:  rd_mux = {1'b0, err_tally_ff[s], err_src_ff[s]};
            uhps_pkg::OFS_IN_REQ_CNT:  rd_mux = in_req_ff[s];
            uhps_pkg::OFS_INT_FLAGS:   rd_mux = flags_rd[s];
            uhps_pkg::OFS_PIPE_SELECT: rd_mux = {6'h00, pipe_select_ff};
            uhps_pkg::OFS_PIPE_CTRL:   rd_mux = {1'b0, freeze_ff[s], inmode_ff[s], 5'h00};
            uhps_pkg::OFS_PIPE_CFG:    rd_mux = cfg_ff[s];
            uhps_pkg::OFS_PIPE_STAT:   rd_mux = {1'b0, ovf_ff[s], unf_ff[s], 3'h0, busy_ff[s]};
            uhps_pkg::OFS_INT_ENABLE:  rd_mux = ie_ff[s];
            default:                   rd_mux = uhps_pkg::RST_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_ff <= uhps_pkg::RST_BYTE;
        end else if (reg_rd) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= uhps_pkg::RST_BYTE;
        end
    end

    // =====================================================================
    // outputs
    assign reg_rdata        = rdata_ff;
    assign pipe_freeze      = freeze_ff;
    assign handover_release = release_ff;
    assign pipe_irq         = summary_ff;

endmodule : uhps_pipe_status

// File: testbench/uhps_pipe_status_checker.sv
// Purpose: port-level checks of the pipe status and interrupt block
// Assumes: one clock, synchronous active-high reset
// Notes:   interrupt summary lags its flag by one cycle, so causes sit two edges back
`timescale 1ns/1ns
module uhps_pipe_status_checker (
    // clock and reset
    input wire logic                ref_clk,
    input wire logic                reset,
    // register port
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    // engine side
    input wire uhps_pkg::uhps_evt_t evt,
    input wire logic [3:0]          pipe_freeze,
    input wire logic [3:0]          handover_release,
    input wire logic [3:0]          pipe_irq
);
    // =====================================================================
    // properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_wrote(logic [7:0] a);
        $past(reg_wr) && $past(reg_addr) == a;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_enable_rsvd_zero: assert property (reg_rd && reg_addr == 8'hae |=> !reg_rdata[5])
        else $error("reserved enable bit reads one");
    a_error_freezes: assert property (evt.valid && (evt.data_crc_error || evt.time_out || evt.pid_err
        || evt.data_pid || evt.toggle) |=> pipe_freeze[$past(evt.pipe)])
        else $error("error did not freeze");
    a_freeze_rise_cause: assert property (|(pipe_freeze & ~$past(pipe_freeze))
        |-> $past(evt.valid) || $past(reg_wr))
        else $error("freeze rose without a cause");
    a_freeze_fall_ctrl: assert property (|(~pipe_freeze & $past(pipe_freeze))
        |-> s_wrote(8'ha9))
        else $error("freeze fell without a control write");
    a_irq_rise_cause: assert property (|(pipe_irq & ~$past(pipe_irq))
        |-> $past(evt.valid, 2) || $past(reg_wr, 2))
        else $error("interrupt rose without a cause");
    a_irq_fall_served: assert property (|(~pipe_irq & $past(pipe_irq)) |-> $past(reg_wr, 2))
        else $error("interrupt fell without a write");
    a_release_cause: assert property (|handover_release |-> s_wrote(8'ha6))
        else $error("bank release without a flag write");
endmodule : uhps_pipe_status_checker

bind uhps_pipe_status uhps_pipe_status_checker chk_u (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .evt(evt), .pipe_freeze(pipe_freeze),
    .handover_release(handover_release), .pipe_irq(pipe_irq));

// File: testbench/uhps_usb_dev_model.sv
// Purpose: attached device answering host transactions as engine events
// Assumes: bench asks for one answer at a time
// Notes:   answer lag of 0..3 cycles models prompt and slow devices
`timescale 1ns/1ns
module uhps_usb_dev_model (
    // clock
    input  wire logic                ref_clk,
    // answer request from the bench
    input  wire logic                dev_req,
    input  wire logic [1:0]          dev_lag,
    input  wire uhps_pkg::uhps_evt_t ask,
    // event seen by the host
    output uhps_pkg::uhps_evt_t      evt = '0
);
    // =====================================================================
    // delayed answer
    uhps_pkg::uhps_evt_t held_ff = '0;
    logic [2:0]          wait_ff = 3'h0;
    always @(posedge ref_clk) begin
        evt <= '0;
        if (dev_req) begin
            held_ff <= ask;
            wait_ff <= {1'b0, dev_lag} + 3'h1;
        end else if (wait_ff != 3'h0) begin
            wait_ff <= wait_ff - 3'h1;
            // an answer lasts one cycle only, then the line idles
            if (wait_ff == 3'h1) evt <= held_ff;
        end
    end
endmodule : uhps_usb_dev_model

// File: testbench/test_usb_host_pipe_status_irq.sv
// Purpose: self-checking bench of the pipe status and interrupt block
// Assumes: pipe 1 is an OUT pipe with all enables, pipe 2 an IN pipe
// Notes:   event masks follow the field order of the engine event struct
`timescale 1ns/1ns
module test_usb_host_pipe_status_irq;
    typedef struct {logic [14:0] m; logic [7:0] a; logic [7:0] d; logic q;} uhps_row_t;
    logic                ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]          reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [3:0]          pipe_freeze, handover_release, pipe_irq;
    logic                dev_req = 1'b0;
    logic [1:0]          dev_lag = 2'h0;
    uhps_pkg::uhps_evt_t ask = '0, evt;
    int                  miscompares = 0, tests_run = 0;
    logic [7:0]          rst_a [5] = '{8'h9d, 8'ha5, 8'ha6, 8'hae, 8'h00};
    uhps_row_t rows [11] = '{'{15'h1000, 8'ha6, 8'h40, 1}, '{15'h0800, 8'ha6, 8'h02, 1},
        '{15'h0200, 8'h9d, 8'h30, 1}, '{15'h0100, 8'h9d, 8'h28, 1}, '{15'h0080, 8'h9d, 8'h24, 1},
        '{15'h0040, 8'h9d, 8'h22, 1}, '{15'h0020, 8'h9d, 8'h21, 1}, '{15'h2000, 8'ha6, 8'h84, 1},
        '{15'h0002, 8'ha6, 8'h20, 0}, '{15'h0010, 8'hac, 8'h41, 1}, '{15'h0008, 8'hac, 8'h21, 1}};
    always #2 ref_clk = ~ref_clk;
    uhps_pipe_status dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .evt(evt), .pipe_freeze(pipe_freeze), .handover_release(handover_release),
        .pipe_irq(pipe_irq));
    uhps_usb_dev_model dev_u (.ref_clk(ref_clk), .dev_req(dev_req), .dev_lag(dev_lag),
        .ask(ask), .evt(evt));
    // =====================================================================
    // tasks
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(n, reg_rdata, e);
    endtask : rd
    task automatic ev(input logic [1:0] p, input logic [14:0] m, input logic [1:0] l);
        @(posedge ref_clk);
        dev_req <= 1'b1; dev_lag <= l; ask <= uhps_pkg::uhps_evt_t'({1'b1, p, m});
        @(posedge ref_clk);
        dev_req <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : ev
    task automatic results;
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    // =====================================================================
    // sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        foreach (rst_a[i]) rd(rst_a[i], 8'h00, "reset value");
        wr(8'ha7, 8'h01); wr(8'haa, 8'h20); wr(8'hae, 8'hff);
        rd(8'hae, 8'hdf, "enable readback");
        foreach (rows[i]) begin
            ev(2'h1, rows[i].m, 2'(i));
            rd(rows[i].a, rows[i].d, "event flags");
            chk("pipe irq", {7'h00, pipe_irq[1]}, {7'h00, rows[i].q});
            wr(8'ha6, 8'h00); wr(8'h9d, 8'h00); wr(8'hac, 8'h00);
        end
        wr(8'ha6, 8'hff);
        rd(8'ha6, 8'h20, "write one ignored");
        ev(2'h2, 15'h1000, 2'h3);
        rd(8'ha6, 8'h20, "other pipe untouched");
        wr(8'ha7, 8'h02); wr(8'haa, 8'h10); wr(8'ha5, 8'h01);
        rd(8'ha6, 8'h40, "banked flags");
        chk("masked irq", {4'h0, pipe_irq}, 8'h00);
        ev(2'h2, 15'h0004, 2'h0);
        rd(8'ha5, 8'h00, "in count step");
        chk("no early freeze", {4'h0, pipe_freeze}, 8'h02);
        ev(2'h2, 15'h0004, 2'h1);
        chk("freeze after count", {4'h0, pipe_freeze}, 8'h06);
        wr(8'ha9, 8'h00);
        ev(2'h2, 15'h0002, 2'h2);
        rd(8'ha6, 8'h60, "rw allowed set");
        repeat (3) ev(2'h2, 15'h0020, 2'h3);
        rd(8'h9d, 8'h61, "tally at three");
        rd(8'ha6, 8'h50, "error drops rw");
        chk("error freeze", {4'h0, pipe_freeze}, 8'h06);
        wr(8'hae, 8'h40); wr(8'h9d, 8'h00);
        rd(8'ha6, 8'h40, "error flag follows");
        chk("irq enabled", {4'h0, pipe_irq}, 8'h04);
        ev(2'h2, 15'h4000, 2'h0); rd(8'hac, 8'h01, "in bank busy");
        wr(8'ha6, 8'h41); #1 chk("in release", {4'h0, handover_release}, 8'h04);
        results();
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        miscompares++;
        results();
    end
endmodule : test_usb_host_pipe_status_irq
